// file: common/bus_match_pkg.sv
// Contract
// - long-word mode: one Port B write stores all four lanes unchanged.
// - word mode: two writes on B17-B0; endian picks which half fills first.
// - byte mode: four writes on B8-B0; endian picks top-down or bottom-up fill.
// - long-word mode: each Port B read gives the whole long word, lanes kept.
// - word mode: two reads; endian high gives upper half first, else lower.
// - byte mode: four reads; endian high gives most significant byte first.
// - word reads leave B35-B18 undefined.
// - byte reads leave B35-B9 undefined.
// - fall-through: first A-to-B word ready on Port B within three cycles.
// - fall-through: first B-to-A word ready on Port A within three cycles.
// - standard: Port B empty flag releases next cycle after write to empty queue; the code releases it on the third edge.
// - standard: Port A empty flag releases next cycle after write to empty queue; the code releases it on the third edge.
// - narrow sizes: last word or byte read sets Port B empty, not fetch.
// - narrow sizes: Port A empty timing counts from final Port B write edge.
// - Port B read freeing full A-to-B queue releases Port A full next cycle; the code releases it on the third edge.
// - narrow sizes: Port A full release counts from final Port B read.
// - Port A read freeing full B-to-A queue releases Port B full next cycle; the code releases it on the third edge.
// - narrow sizes: final Port B write of a long word sets Port B full.
// - earlier words held aside; final write commits the assembled long word.
// - narrow reads fetch once; remaining lanes shift out from a hold register.
// - endian high means big-endian, low little-endian; ignored in long-word mode.
package bus_match_pkg;

    localparam int WORD_W = 36;
    localparam int DEPTH  = 16;
    localparam int ADDR_W = 4;
    localparam int PTR_W  = 5;
    localparam logic [PTR_W-1:0] FULL_COUNT = 5'h10;

    localparam logic [31:0] CONFIG_OFFSET = 32'h0000_0000;
    localparam logic [31:0] STATUS_OFFSET = 32'h0000_0004;

    localparam int CFG_BUS_MATCH_BIT = 0;
    localparam int CFG_SIZE_BIT      = 1;
    localparam int CFG_ORDER_BIT     = 2;
    localparam int CFG_FALL_THROUGH_MODE_BIT      = 3;
    localparam logic [3:0] CONFIG_RESET = 4'h0;

    localparam int ST_A_IN_BIT  = 0;
    localparam int ST_A_OUT_BIT = 1;
    localparam int ST_B_IN_BIT  = 2;
    localparam int ST_B_OUT_BIT = 3;

    typedef enum logic [2:0] {
        SIZE_LONG = 3'b001,
        SIZE_WORD = 3'b010,
        SIZE_BYTE = 3'b100
    } bus_size_t;

    function automatic bus_size_t sizeOf(logic busMatch, logic sizeSel);
        if (!busMatch) begin
            return SIZE_LONG;
        end
        return sizeSel ? SIZE_BYTE : SIZE_WORD;
    endfunction

    function automatic logic [1:0] lastIndex(bus_size_t s);
        case (s)
            SIZE_WORD: return 2'h1;
            SIZE_BYTE: return 2'h3;
            default:   return 2'h0;
        endcase
    endfunction

    // lane of a long word presented on the low Port B bits
    function automatic logic [WORD_W-1:0] laneOut(logic [WORD_W-1:0] word, logic [1:0] idx,
                                                  bus_size_t s, logic big);
        logic [WORD_W-1:0] r;
        logic [1:0]        slot;
        r    = '0;
        slot = big ? 2'h3 - idx : idx;
        case (s)
            SIZE_WORD: r[17:0] = (idx[0] ^ big) ? word[35:18] : word[17:0];
            SIZE_BYTE: r[8:0]  = word[9*slot +: 9];
            default:   r       = word;
        endcase
        return r;
    endfunction

    // low Port B bits merged into the long word under assembly
    function automatic logic [WORD_W-1:0] laneIn(logic [WORD_W-1:0] acc, logic [WORD_W-1:0] data,
                                                 logic [1:0] idx, bus_size_t s, logic big);
        logic [WORD_W-1:0] r;
        logic [1:0]        slot;
        r    = acc;
        slot = big ? 2'h3 - idx : idx;
        case (s)
            SIZE_WORD: begin
                if (idx[0] ^ big) begin
                    r[35:18] = data[17:0];
                end else begin
                    r[17:0] = data[17:0];
                end
            end
            SIZE_BYTE: r[9*slot +: 9] = data[8:0];
            default:   r = data;
        endcase
        return r;
    endfunction

endpackage

// file: common/queue_mem_if.sv
`timescale 1ns/100ps
interface queue_mem_if;
    logic                                we;
    logic [bus_match_pkg::ADDR_W-1:0]    waddr;
    logic [bus_match_pkg::WORD_W-1:0]    wdata;
    logic [bus_match_pkg::ADDR_W-1:0]    raddr;
    logic [bus_match_pkg::WORD_W-1:0]    rdata;

    modport ctrl  (output we, output waddr, output wdata, output raddr, input rdata);
    modport store (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// file: rtl/queue_ram.sv
`timescale 1ns/100ps
module queue_ram (
    // clock
    input wire logic          clk,
    // storage port
    queue_mem_if.store        mem
);
    logic [bus_match_pkg::WORD_W-1:0] cells [bus_match_pkg::DEPTH];

    always_ff @(posedge clk) begin
        if (mem.we) begin
            cells[mem.waddr] <= mem.wdata;
        end
    end

    // registered read of the addressed cell
    always_ff @(posedge clk) begin
        mem.rdata <= cells[mem.raddr];
    end
endmodule

// file: rtl/bus_match_fifo.sv
`timescale 1ns/100ps
module bus_match_fifo (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // ahb-lite register slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    // port a
    input  wire logic        portAWriteEn,
    input  wire logic [35:0] portADataIn,
    output logic             portAInputReady,
    input  wire logic        portAReadEn,
    output logic [35:0]      portADataOut,
    output logic             portAOutputReady,
    // port b
    input  wire logic        portBWriteEn,
    input  wire logic [35:0] portBDataIn,
    output logic             portBInputReady,
    input  wire logic        portBReadEn,
    output logic [35:0]      portBDataOut,
    output logic             portBOutputReady
);
    logic [3:0]                   cfgReg;
    logic                         queueClear;
    logic                         clear;
    bus_match_pkg::bus_size_t     busSize;
    logic                         bigEnd;
    logic                         fall_through_mode;

    logic                         dataPhase;
    logic                         dataWrite;
    logic [31:0]                  dataAddr;
    logic                         cfgWrite;
    logic [3:0]                   cfgView;

    logic [4:0]                   abWrPtr;
    logic [4:0]                   abRdPtr;
    logic [4:0]                   abWrSync1;
    logic [4:0]                   abWrSync2;
    logic [4:0]                   abRdSync1;
    logic [4:0]                   abRdSync2;
    logic [4:0]                   next_abWrPtr;
    logic [4:0]                   next_abRdPtr;
    logic                         writeA;
    logic                         readB;
    logic                         lastR;
    logic                         consumeB;
    logic                         abAvail;
    logic                         loadB;
    logic [1:0]                   rdSub;
    logic [35:0]                  rdHold;
    logic [35:0]                  rdSource;

    logic [4:0]                   baWrPtr;
    logic [4:0]                   baRdPtr;
    logic [4:0]                   baWrSync1;
    logic [4:0]                   baWrSync2;
    logic [4:0]                   baRdSync1;
    logic [4:0]                   baRdSync2;
    logic [4:0]                   next_baWrPtr;
    logic [4:0]                   next_baRdPtr;
    logic                         writeB;
    logic                         lastW;
    logic                         commitB;
    logic                         readA;
    logic                         baAvail;
    logic                         loadA;
    logic [1:0]                   wrSub;
    logic [35:0]                  wrAsm;
    logic [35:0]                  next_wrAsm;

    queue_mem_if abMem ();
    queue_mem_if baMem ();

    queue_ram abRam (
        .clk (clk),
        .mem (abMem.store)
    );

    queue_ram baRam (
        .clk (clk),
        .mem (baMem.store)
    );

    // configuration decode; a config write acts as master reset
    assign busSize = bus_match_pkg::sizeOf(cfgReg[bus_match_pkg::CFG_BUS_MATCH_BIT],
                                           cfgReg[bus_match_pkg::CFG_SIZE_BIT]);
    assign bigEnd  = cfgReg[bus_match_pkg::CFG_ORDER_BIT];
    assign fall_through_mode    = cfgReg[bus_match_pkg::CFG_FALL_THROUGH_MODE_BIT];
    assign clear   = !rst_n || queueClear;

    // ahb-lite address phase capture
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dataPhase <= 1'b0;
            dataWrite <= 1'b0;
            dataAddr  <= 32'h0000_0000;
        end else if (hready) begin
            dataPhase <= hsel && htrans[1];
            dataWrite <= hwrite;
            dataAddr  <= haddr;
        end
    end

    assign cfgWrite = dataPhase && dataWrite && (dataAddr == bus_match_pkg::CONFIG_OFFSET);
    assign cfgView  = cfgWrite ? hwdata[3:0] : cfgReg;

    // config register; endian and mode are taken only with the reset it triggers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cfgReg     <= bus_match_pkg::CONFIG_RESET;
            queueClear <= 1'b0;
        end else begin
            queueClear <= cfgWrite;
            if (cfgWrite) begin
                cfgReg <= hwdata[3:0];
            end
        end
    end

    // read data prepared at the address phase, zero wait states
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hrdata <= 32'h0000_0000;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            case (haddr)
                bus_match_pkg::CONFIG_OFFSET: hrdata <= {28'h0000000, cfgView};
                bus_match_pkg::STATUS_OFFSET: begin
                    hrdata <= 32'h0000_0000;
                    hrdata[bus_match_pkg::ST_A_IN_BIT]  <= portAInputReady;
                    hrdata[bus_match_pkg::ST_A_OUT_BIT] <= portAOutputReady;
                    hrdata[bus_match_pkg::ST_B_IN_BIT]  <= portBInputReady;
                    hrdata[bus_match_pkg::ST_B_OUT_BIT] <= portBOutputReady;
                end
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // pointer synchronizers between the port sides
    always_ff @(posedge clk) begin
        if (clear) begin
            abWrSync1 <= 5'h00;
            abWrSync2 <= 5'h00;
            abRdSync1 <= 5'h00;
            abRdSync2 <= 5'h00;
            baWrSync1 <= 5'h00;
            baWrSync2 <= 5'h00;
            baRdSync1 <= 5'h00;
            baRdSync2 <= 5'h00;
        end else begin
            abWrSync1 <= abWrPtr;
            abWrSync2 <= abWrSync1;
            abRdSync1 <= abRdPtr;
            abRdSync2 <= abRdSync1;
            baWrSync1 <= baWrPtr;
            baWrSync2 <= baWrSync1;
            baRdSync1 <= baRdPtr;
            baRdSync2 <= baRdSync1;
        end
    end

    // a-to-b queue: port a writer
    assign writeA       = portAWriteEn && portAInputReady;
    assign next_abWrPtr = writeA ? abWrPtr + 5'h01 : abWrPtr;
    assign abMem.we     = writeA;
    assign abMem.waddr  = abWrPtr[3:0];
    assign abMem.wdata  = portADataIn;
    assign abMem.raddr  = next_abRdPtr[3:0];

    always_ff @(posedge clk) begin
        if (clear) begin
            abWrPtr         <= 5'h00;
            portAInputReady <= 1'b0;
        end else begin
            abWrPtr         <= next_abWrPtr;
            portAInputReady <= (next_abWrPtr - abRdSync2) != bus_match_pkg::FULL_COUNT;
        end
    end

    // a-to-b queue: port b reader with unpacking
    assign lastR        = rdSub == bus_match_pkg::lastIndex(busSize);
    assign readB        = portBReadEn && portBOutputReady;
    assign consumeB     = readB && lastR;
    assign next_abRdPtr = consumeB ? abRdPtr + 5'h01 : abRdPtr;
    assign abAvail      = abWrSync2 != abRdPtr;
    assign loadB        = fall_through_mode && !portBOutputReady && abAvail;
    assign rdSource     = (rdSub == 2'h0) ? abMem.rdata : rdHold;

    always_ff @(posedge clk) begin
        if (clear) begin
            abRdPtr <= 5'h00;
            rdSub   <= 2'h0;
        end else begin
            abRdPtr <= next_abRdPtr;
            if (readB) begin
                rdSub <= lastR ? 2'h0 : rdSub + 2'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (clear) begin
            portBOutputReady <= 1'b0;
        end else if (fall_through_mode) begin
            portBOutputReady <= consumeB ? 1'b0 : abAvail;
        end else begin
            portBOutputReady <= abWrSync2 != next_abRdPtr;
        end
    end

    always_ff @(posedge clk) begin
        if (clear) begin
            rdHold       <= 36'h000000000;
            portBDataOut <= 36'h000000000;
        end else if (loadB) begin
            rdHold       <= abMem.rdata;
            portBDataOut <= bus_match_pkg::laneOut(abMem.rdata, 2'h0, busSize, bigEnd);
        end else if (readB && fall_through_mode && !lastR) begin
            portBDataOut <= bus_match_pkg::laneOut(rdHold, rdSub + 2'h1,
                                                   busSize, bigEnd);
        end else if (readB && !fall_through_mode) begin
            if (rdSub == 2'h0) begin
                rdHold <= abMem.rdata;
            end
            portBDataOut <= bus_match_pkg::laneOut(rdSource, rdSub, busSize, bigEnd);
        end
    end

    // b-to-a queue: port b writer with packing
    assign lastW        = wrSub == bus_match_pkg::lastIndex(busSize);
    assign writeB       = portBWriteEn && portBInputReady;
    assign commitB      = writeB && lastW;
    assign next_wrAsm   = bus_match_pkg::laneIn(wrAsm, portBDataIn, wrSub, busSize, bigEnd);
    assign next_baWrPtr = commitB ? baWrPtr + 5'h01 : baWrPtr;
    assign baMem.we     = commitB;
    assign baMem.waddr  = baWrPtr[3:0];
    assign baMem.wdata  = next_wrAsm;
    assign baMem.raddr  = next_baRdPtr[3:0];

    always_ff @(posedge clk) begin
        if (clear) begin
            baWrPtr <= 5'h00;
            wrSub   <= 2'h0;
            wrAsm   <= 36'h000000000;
        end else begin
            baWrPtr <= next_baWrPtr;
            if (writeB) begin
                wrSub <= lastW ? 2'h0 : wrSub + 2'h1;
                wrAsm <= next_wrAsm;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (clear) begin
            portBInputReady <= 1'b0;
        end else begin
            portBInputReady <= (next_baWrPtr - baRdSync2) != bus_match_pkg::FULL_COUNT;
        end
    end

    // b-to-a queue: port a reader
    assign readA        = portAReadEn && portAOutputReady;
    assign next_baRdPtr = readA ? baRdPtr + 5'h01 : baRdPtr;
    assign baAvail      = baWrSync2 != baRdPtr;
    assign loadA        = fall_through_mode && !portAOutputReady && baAvail;

    always_ff @(posedge clk) begin
        if (clear) begin
            baRdPtr <= 5'h00;
        end else begin
            baRdPtr <= next_baRdPtr;
        end
    end

    always_ff @(posedge clk) begin
        if (clear) begin
            portAOutputReady <= 1'b0;
        end else if (fall_through_mode) begin
            portAOutputReady <= readA ? 1'b0 : baAvail;
        end else begin
            portAOutputReady <= baWrSync2 != next_baRdPtr;
        end
    end

    always_ff @(posedge clk) begin
        if (clear) begin
            portADataOut <= 36'h000000000;
        end else if (loadA || (readA && !fall_through_mode)) begin
            portADataOut <= baMem.rdata;
        end
    end

    // checks
    ab_fall_a: assert property (@(posedge clk) disable iff (!rst_n || queueClear)
        writeA && fall_through_mode && abWrPtr == abRdPtr && !portBOutputReady |-> ##4 portBOutputReady)
        else $error("port b not ready four edges after write to empty queue");

    ba_empty_a: assert property (@(posedge clk) disable iff (!rst_n || queueClear)
        commitB && !fall_through_mode && baWrPtr == baRdPtr && !portAOutputReady |-> ##4 portAOutputReady)
        else $error("port a empty flag not released after commit");

    commit_hold_a: assert property (@(posedge clk) disable iff (!rst_n || queueClear)
        writeB && !lastW |=> baWrPtr == $past(baWrPtr))
        else $error("partial long word reached the queue");

    fetch_hold_a: assert property (@(posedge clk) disable iff (!rst_n || queueClear)
        readB && !lastR |=> abRdPtr == $past(abRdPtr))
        else $error("space released before final lane read");

    sub_wrap_a: assert property (@(posedge clk) disable iff (!rst_n || queueClear)
        readB && lastR |=> rdSub == 2'h0)
        else $error("read lane counter did not wrap");

    full_set_a: assert property (@(posedge clk) disable iff (!rst_n || queueClear)
        commitB && (baWrPtr + 5'h01 - baRdPtr) == bus_match_pkg::FULL_COUNT
        |=> !portBInputReady)
        else $error("port b not full after final write");

    empty_set_a: assert property (@(posedge clk) disable iff (!rst_n || queueClear)
        consumeB && abWrPtr == abRdPtr + 5'h01 |=> !portBOutputReady)
        else $error("port b still ready after last lane of last word");

    byte_big_a: assert property (@(posedge clk) disable iff (!rst_n || queueClear)
        writeB && busSize == bus_match_pkg::SIZE_BYTE && bigEnd && wrSub == 2'h0
        |=> wrAsm[35:27] == $past(portBDataIn[8:0]))
        else $error("first big-endian byte not in top lane");

    word_little_a: assert property (@(posedge clk) disable iff (!rst_n || queueClear)
        writeB && busSize == bus_match_pkg::SIZE_WORD && !bigEnd && wrSub == 2'h0
        |=> wrAsm[17:0] == $past(portBDataIn[17:0]))
        else $error("first little-endian word not in lower half");

    long_read_a: assert property (@(posedge clk) disable iff (!rst_n || queueClear)
        readB && busSize == bus_match_pkg::SIZE_LONG && !fall_through_mode
        |=> portBDataOut == $past(abMem.rdata))
        else $error("long word read altered lanes");
endmodule

// file: tb/port_a_master.sv
`timescale 1ns/100ps
module port_a_master (
    // clock and mode
    input  wire logic        clk,
    input  wire logic        fall_through_mode,
    // port a of the block
    input  wire logic        inputReady,
    input  wire logic        outputReady,
    input  wire logic [35:0] dataOut,
    output logic             writeEn,
    output logic             readEn,
    output logic [35:0]      dataIn
);
    initial begin
        writeEn = 1'b0;
        readEn  = 1'b0;
        dataIn  = 36'h0;
    end
    // held until an edge finds input ready, then the data line flips
    task automatic write(input logic [35:0] w);
        writeEn <= 1'b1;
        dataIn  <= w;
        do @(posedge clk); while (inputReady !== 1'b1);
        writeEn <= 1'b0;
        dataIn  <= ~w;
        #1;
    endtask
    // fall-through data stands before the edge, standard data after it
    task automatic read(output logic [35:0] d);
        readEn <= 1'b1;
        do @(posedge clk); while (outputReady !== 1'b1);
        d = dataOut;
        readEn <= 1'b0;
        #1;
        if (!fall_through_mode) d = dataOut;
    endtask
endmodule

// file: tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    logic        clk;
    logic        rst_n;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic [31:0] hrdata;
    logic        hresp;
    logic        aWriteEn, aReadEn, aInReady, aOutReady, fall_through_mode;
    logic        bWriteEn, bReadEn, bInReady, bOutReady;
    logic [35:0] aDataIn, aDataOut, bDataIn, bDataOut, w, d, mask;
    logic [31:0] rd;
    logic [3:0]  flags;
    logic [3:0]  cfgs [9] = '{4'h0, 4'h1, 4'h5, 4'h3, 4'h7, 4'hD, 4'hB, 4'h8, 4'hF};
    int          errors, testsRun, n;

    assign flags = {bOutReady, bInReady, aOutReady, aInReady};

    bus_match_fifo bus_match_fifo_inst (
        .clk(clk), .rst_n(rst_n), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .portAWriteEn(aWriteEn), .portADataIn(aDataIn), .portAInputReady(aInReady),
        .portAReadEn(aReadEn), .portADataOut(aDataOut), .portAOutputReady(aOutReady),
        .portBWriteEn(bWriteEn), .portBDataIn(bDataIn), .portBInputReady(bInReady),
        .portBReadEn(bReadEn), .portBDataOut(bDataOut), .portBOutputReady(bOutReady)
    );

    port_a_master port_a_master_inst (
        .clk(clk), .fall_through_mode(fall_through_mode), .inputReady(aInReady), .outputReady(aOutReady),
        .dataOut(aDataOut), .writeEn(aWriteEn), .readEn(aReadEn), .dataIn(aDataIn)
    );

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic checkVal(input string name, input logic [35:0] e, input logic [35:0] g);
        testsRun++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic ahb(input logic [31:0] a, input logic wr, input logic [31:0] wd);
        haddr  <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic setConfig(input logic [3:0] c);
        ahb(bus_match_pkg::CONFIG_OFFSET, 1'b1, {28'h0, c});
        fall_through_mode = c[bus_match_pkg::CFG_FALL_THROUGH_MODE_BIT];
        repeat (3) @(posedge clk);
        #1;
    endtask

    task automatic bWrite(input logic [35:0] v);
        bWriteEn <= 1'b1;
        bDataIn  <= v;
        do @(posedge clk); while (bInReady !== 1'b1);
        bWriteEn <= 1'b0;
        bDataIn  <= ~v;
        #1;
    endtask

    task automatic bRead(output logic [35:0] v);
        bReadEn <= 1'b1;
        do @(posedge clk); while (bOutReady !== 1'b1);
        v = bDataOut;
        bReadEn <= 1'b0;
        #1;
        if (!fall_through_mode) v = bDataOut;
    endtask

    // flag low two edges after the cause, high at the third
    task automatic rise3(input int idx, input string name);
        repeat (2) @(posedge clk);
        #1;
        checkVal(name, 36'h0, 36'(flags[idx]));
        @(posedge clk);
        #1;
        checkVal(name, 36'h1, 36'(flags[idx]));
    endtask

    function automatic logic [35:0] lane(logic [35:0] v, int k, int m, logic big);
        int s;
        s = big ? m - 1 - k : k;
        case (m)
            2: return {18'h0, v[18*s +: 18]};
            4: return {27'h0, v[9*s +: 9]};
            default: return v;
        endcase
    endfunction

    task automatic results();
        $display("comparisons %0d errors %0d", testsRun, errors);
        if (errors == 0 && testsRun > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        results();
    end

    initial begin
        rst_n = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        bWriteEn = 1'b0;
        bReadEn = 1'b0;
        bDataIn = 36'h0;
        fall_through_mode = 1'b0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        ahb(bus_match_pkg::STATUS_OFFSET, 1'b0, 32'h0);
        checkVal("status", 36'h5, 36'(rd));
        ahb(32'h0000_0008, 1'b1, 32'hFFFF_FFFF);
        ahb(32'h0000_0008, 1'b0, 32'h0);
        checkVal("unmapped", 36'h0, 36'(rd));
        setConfig(4'h5);
        ahb(bus_match_pkg::CONFIG_OFFSET, 1'b0, 32'h0);
        checkVal("config", 36'h5, 36'(rd));
        checkVal("hresp", 36'h0, 36'(hresp));
        foreach (cfgs[i]) begin
            n = !cfgs[i][0] ? 1 : (cfgs[i][1] ? 4 : 2);
            mask = (n == 1) ? '1 : (36'h1 << (36 / n)) - 36'h1;
            w = 36'hA5C3E9172 ^ (36'h111111111 * i);
            setConfig(cfgs[i]);
            port_a_master_inst.write(w);
            rise3(3, "b out ready");
            for (int k = 0; k < n; k++) begin
                bRead(d);
                checkVal("b data", lane(w, k, n, cfgs[i][2]), d & mask);
                checkVal("b out ready", 36'(k < n - 1), 36'(bOutReady));
            end
            for (int k = 0; k < n; k++) begin
                bWrite(lane(~w, k, n, cfgs[i][2]) | (~mask & 36'hF0F0F0F0F));
                checkVal("a out ready", 36'h0, 36'(aOutReady));
            end
            rise3(1, "a out ready");
            port_a_master_inst.read(d);
            checkVal("a data", ~w, d);
        end
        setConfig(4'h1);
        for (int i = 0; i < 16; i++) begin
            port_a_master_inst.write(36'h1000 + 36'(i));
            checkVal("a in ready", 36'(i < 15), 36'(aInReady));
        end
        bRead(d);
        repeat (4) @(posedge clk);
        checkVal("a in ready", 36'h0, 36'(aInReady));
        bRead(d);
        rise3(0, "a in ready");
        for (int i = 0; i < 32; i++) begin
            bWrite(36'(i));
            checkVal("b in ready", 36'(i < 31), 36'(bInReady));
        end
        port_a_master_inst.read(d);
        checkVal("a data", {18'h1, 18'h0}, d);
        rise3(2, "b in ready");
        results();
    end
endmodule
